// ### fxu_defs.vh
// Constants for the numeric exception and initialisation unit
`ifndef FXU_DEFS_VH
`define FXU_DEFS_VH
// Register word addresses
`define FXU_A_CTRL 4'h0
`define FXU_A_STAT 4'h1
`define FXU_A_TAG 4'h2
`define FXU_A_IPTR 4'h3
`define FXU_A_DPTR 4'h4
`define FXU_A_OPC 4'h5
`define FXU_A_CMD 4'h6
// Reset and init values
`define FXU_CW_INIT 16'h037f
`define FXU_TAG_EMPTY 16'hffff
`define FXU_TAG_E 2'h3
`define FXU_TOP_PUSH1 3'h7
// Control word fields
`define FXU_CW_MASK 5:0
`define FXU_CW_IC 12
`define FXU_CW_RC 11:10
// Status word fields
`define FXU_SW_FLAGS 5:0
`define FXU_SW_SF 6
`define FXU_SW_ES 7
`define FXU_SW_C0 8
`define FXU_SW_C1 9
`define FXU_SW_C2 10
`define FXU_SW_TOP 13:11
`define FXU_SW_C3 14
`define FXU_SW_B 15
// Exception bit positions
`define FXU_X_IE 0
`define FXU_X_DE 1
`define FXU_X_ZE 2
`define FXU_X_OE 3
`define FXU_X_UE 4
`define FXU_X_PE 5
// Rounding modes
`define FXU_RC_NEAR 2'h0
`define FXU_RC_DOWN 2'h1
`define FXU_RC_UP 2'h2
`define FXU_RC_CHOP 2'h3
// Operation classes
`define FXU_OP_ARITH 4'h0
`define FXU_OP_LOAD_SD 4'h1
`define FXU_OP_LOAD_EXT 4'h2
`define FXU_OP_COMPARE 4'h3
`define FXU_OP_STORE_INT 4'h4
`define FXU_OP_STORE_BCD 4'h5
`define FXU_OP_SPLIT_EXP 4'h6
`define FXU_OP_SCALE 4'h7
`define FXU_OP_PREM 4'h8
// Command register codes
`define FXU_CMD_INIT 3'h1
`define FXU_CMD_CLEX 3'h2
`define FXU_CMD_ENV 3'h3
`define FXU_CMD_PREM_INC 3'h4
// Register field slices
`define FXU_CMD_CODE 2:0
`define FXU_SW_LOW 7:0
`define FXU_SW_CC 10:8
// Masked default result codes
`define FXU_R_NONE 4'h0
`define FXU_R_QNAN 4'h1
`define FXU_R_INT_IND 4'h2
`define FXU_R_BCD_IND 4'h3
`define FXU_R_INF 4'h4
`define FXU_R_MAXFIN 4'h5
`define FXU_R_DENORM 4'h6
`define FXU_R_ZERO 4'h7
`define FXU_R_ROUNDED 4'h8
`define FXU_R_NORMOP 4'h9
`define FXU_R_NEG_INF_ST1 4'ha
`endif

// ### fxu_exc_unit.v
// Exception detection, flagging, reporting and init state for the NPU
// How it works
// - Six exceptions ranked invalid first, inexact last
// - Masked invalid yields quiet NaN or indefinite
// - Masked denormal operand gets normalised, continue
// - Zero divisor, finite dividend: zero-divide, infinity
// - Masked overflow: max finite or infinity per rounding
// - Masked underflow flags only on accuracy loss
// - Inexact rounds by mode, continues when masked
// - Unmasked exception sets flag, summary, error pin
// - Keep faulting instruction and operand addresses
// - Reset or init loads control word 037f
// - Init clears bit 12; infinity always affine
// - Init clears flags, top, busy bit
// - Init sets tag word to all empty
// - Clear condition codes on reset, init, remainder
// - Tag writes may only mark entries empty
// - Stack fault bit set on unmasked stack invalid
// - Split exponent of zero: zero-divide, minus infinity
// - Only quiet NaNs; signalling NaN raises invalid
// - Scale by infinity: invalid, zero or infinity
// - Single/double load: denormal, NaN checks; extended skips denormal only
// - Error pin follows summary, set only while busy
`include "fxu_defs.vh"
module fxu_exc_unit (
  input wire clk_i, // 125 MHz clock
  input wire rst_i, // Synchronous reset, high
  // Wishbone slave
  input wire wb_cyc_i, // Bus cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write enable
  input wire [5:2] wb_adr_i, // Word address
  input wire [3:0] wb_sel_i, // Byte selects
  input wire [31:0] wb_dat_i, // Write data
  output reg [31:0] wb_dat_o, // Read data
  output wire wb_ack_o, // Acknowledge
  // Datapath report, one-cycle per finished operation
  input wire op_done_i, // Operation finished
  input wire [3:0] op_class_i, // Operation class
  input wire op_snan_i, // Signalling NaN operand
  input wire op_qnan_i, // Quiet NaN operand
  input wire op_badfmt_i, // Unsupported format
  input wire op_indet_i, // Indeterminate form
  input wire op_stack_i, // Stack over/underflow
  input wire op_denorm_i, // Denormal operand
  input wire op_divzero_i, // Zero divisor, finite nonzero dividend
  input wire op_zero_i, // Operand is zero
  input wire op_scl_inf_i, // Scale factor infinite
  input wire op_scl_neg_i, // Scale factor negative
  input wire op_ovf_i, // Result overflow
  input wire op_tiny_i, // Result tiny
  input wire op_lossy_i, // Denormalisation lost accuracy
  input wire op_inexact_i, // Result not exact
  input wire op_res_neg_i, // Result sign
  input wire op_int_dst_i, // Destination integer
  input wire op_bcd_dst_i, // Destination decimal
  input wire op_has_mem_i, // Has memory operand
  input wire [3:0] cc_i, // New condition codes
  input wire cc_we_i, // Load condition codes
  input wire [2:0] top_i, // New stack top
  input wire top_we_i, // Load stack top
  input wire [7:0] tag_valid_i, // Register holds data
  input wire esc_start_i, // New escape instruction begins
  input wire [19:0] esc_ip_i, // Its address
  input wire [19:0] esc_dp_i, // Its operand address
  input wire [10:0] esc_opc_i, // Its opcode
  input wire busy_i, // Execution unit busy
  output reg [3:0] res_kind_o, // Masked default result kind
  output reg res_neg_o, // Default result sign
  output reg res_valid_o, // Result kind valid pulse
  output reg stall_o, // Unmasked exception stops operation
  output wire [1:0] rnd_mode_o, // Active rounding mode
  output wire affine_o, // Infinity closure, always affine
  output reg error_n_o // Error pin, low active
);

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  reg [15:0] ctrl;
  reg [15:0] stat;
  reg [15:0] tag;
  reg [19:0] ip_save;
  reg [19:0] dp_save;
  reg [10:0] opc_save;
  reg [19:0] ip_cur;
  reg [19:0] dp_cur;
  reg [10:0] opc_cur;
  reg ack;

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire wr = bus_req & wb_we_i & ~ack & wb_sel_i[0] & wb_sel_i[1];
  wire cmd_wr = wr & (wb_adr_i == `FXU_A_CMD);
  wire [2:0] cmd_code = wb_dat_i[`FXU_CMD_CODE];
  wire do_init = rst_i | (cmd_wr & (cmd_code == `FXU_CMD_INIT));
  wire do_clex = cmd_wr & (cmd_code == `FXU_CMD_CLEX);
  wire do_env = cmd_wr & (cmd_code == `FXU_CMD_ENV);
  wire prem_inc = cmd_wr & (cmd_code == `FXU_CMD_PREM_INC);
  wire ctrl_wr = wr & (wb_adr_i == `FXU_A_CTRL);
  wire stat_wr = wr & (wb_adr_i == `FXU_A_STAT);
  wire tag_wr = wr & (wb_adr_i == `FXU_A_TAG);
  // Any of these lets software release the error pin
  wire err_clear = do_init | do_clex | do_env | ctrl_wr;

  assign wb_ack_o = ack;
  assign rnd_mode_o = ctrl[`FXU_CW_RC];
  assign affine_o = 1'b1;

  // Pick the masked overflow result from rounding and sign
  function [3:0] ovf_result;
    input [1:0] rc;
    input neg;
    begin
      case (rc)
        `FXU_RC_NEAR: ovf_result = `FXU_R_INF;
        `FXU_RC_UP: ovf_result = neg ? `FXU_R_MAXFIN : `FXU_R_INF;
        `FXU_RC_DOWN: ovf_result = neg ? `FXU_R_INF : `FXU_R_MAXFIN;
        default: ovf_result = `FXU_R_MAXFIN;
      endcase
    end
  endfunction

  // ----------------------------------------------------------
  // Exception classification
  // ----------------------------------------------------------
  reg [5:0] raised;
  reg [3:0] kind;
  reg kneg;
  reg sf_hit;
  wire [5:0] mask = ctrl[`FXU_CW_MASK];
  wire [5:0] unmasked = raised & ~mask;
  // A finished operation with an unmasked exception is a fault
  wire fault = op_done_i & (|unmasked);

  // Class decodes shared by raise and default-result logic
  wire cls_split = (op_class_i == `FXU_OP_SPLIT_EXP);
  wire cls_scale = (op_class_i == `FXU_OP_SCALE);
  // Quiet NaNs trap only where a NaN cannot be passed on
  wire qnan_traps = (op_class_i == `FXU_OP_COMPARE) |
                    (op_class_i == `FXU_OP_STORE_INT) |
                    (op_class_i == `FXU_OP_STORE_BCD);

  // Raise conditions per operation class
  always @* begin
    raised = 6'h00;
    sf_hit = op_stack_i;
    // Invalid: signalling NaN, format, indeterminate, stack
    raised[`FXU_X_IE] = op_snan_i | op_badfmt_i | op_indet_i |
                        op_stack_i;
    // Quiet NaN only counts for compare and stores
    if (op_qnan_i & qnan_traps)
      raised[`FXU_X_IE] = 1'b1;
    // Extended load is not numeric, no denormal
    raised[`FXU_X_DE] = op_denorm_i &
                        (op_class_i != `FXU_OP_LOAD_EXT);
    raised[`FXU_X_ZE] = op_divzero_i;
    if (cls_split & op_zero_i)
      raised[`FXU_X_ZE] = 1'b1;
    if (cls_scale & op_scl_inf_i & op_zero_i)
      raised[`FXU_X_IE] = 1'b1;
    raised[`FXU_X_OE] = op_ovf_i;
    // Masked underflow flags only on accuracy loss
    raised[`FXU_X_UE] = op_tiny_i &
                        (~ctrl[`FXU_X_UE] | op_lossy_i);
    raised[`FXU_X_PE] = op_inexact_i;
  end

  // Masked default action, taken in precedence order
  always @* begin
    kind = `FXU_R_NONE;
    kneg = op_res_neg_i;
    if (raised[`FXU_X_IE]) begin
      if (op_int_dst_i)
        kind = `FXU_R_INT_IND;
      else if (op_bcd_dst_i)
        kind = `FXU_R_BCD_IND;
      else
        kind = `FXU_R_QNAN;
    end else if (raised[`FXU_X_DE]) begin
      kind = `FXU_R_NORMOP;
    end else if (raised[`FXU_X_ZE]) begin
      if (cls_split) begin
        kind = `FXU_R_NEG_INF_ST1;
        kneg = 1'b1;
      end else
        kind = `FXU_R_INF;
    end else if (cls_scale & op_scl_inf_i) begin
      // Finite value keeps its sign
      kind = op_scl_neg_i ? `FXU_R_ZERO : `FXU_R_INF;
    end else if (raised[`FXU_X_OE]) begin
      kind = ovf_result(ctrl[`FXU_CW_RC], op_res_neg_i);
    end else if (op_tiny_i) begin
      kind = op_lossy_i ? `FXU_R_ZERO : `FXU_R_DENORM;
    end else if (raised[`FXU_X_PE]) begin
      kind = `FXU_R_ROUNDED;
    end
  end

  // ----------------------------------------------------------
  // Result report to the datapath
  // ----------------------------------------------------------
  // Unmasked exception suppresses the default result
  always @(posedge clk_i) begin
    if (rst_i) begin
      res_kind_o <= `FXU_R_NONE;
      res_neg_o <= 1'b0;
      res_valid_o <= 1'b0;
      stall_o <= 1'b0;
    end else begin
      res_valid_o <= op_done_i;
      // Stall pairs with the valid pulse of the same operation
      stall_o <= fault;
      if (op_done_i) begin
        // A trapped operation gets no default; its handler decides
        res_kind_o <= (|unmasked) ? `FXU_R_NONE : kind;
        res_neg_o <= kneg;
      end
    end
  end

  // ----------------------------------------------------------
  // Instruction and operand pointers
  // ----------------------------------------------------------
  // Latched at escape start, frozen for the handler on fault
  always @(posedge clk_i) begin
    if (rst_i) begin
      ip_cur <= 20'h00000;
      dp_cur <= 20'h00000;
      opc_cur <= 11'h000;
      ip_save <= 20'h00000;
      dp_save <= 20'h00000;
      opc_save <= 11'h000;
    end else begin
      if (esc_start_i) begin
        ip_cur <= esc_ip_i;
        dp_cur <= esc_dp_i;
        opc_cur <= esc_opc_i;
      end
      if (fault) begin
        ip_save <= ip_cur;
        // Zero stands in when there is no memory operand
        dp_save <= op_has_mem_i ? dp_cur : 20'h00000;
        opc_save <= opc_cur;
      end
    end
  end

  // ----------------------------------------------------------
  // Control word
  // ----------------------------------------------------------
  // Reset and init load the default word
  always @(posedge clk_i) begin
    if (do_init)
      ctrl <= `FXU_CW_INIT;
    else if (ctrl_wr)
      ctrl <= wb_dat_i[15:0];
  end

  // ----------------------------------------------------------
  // Status word
  // ----------------------------------------------------------
  // Flag base after this cycle's clear or software write;
  // the fault logic ORs its new flags on top of it
  reg [5:0] flag_base;
  always @* begin
    flag_base = stat[`FXU_SW_FLAGS];
    if (do_clex)
      flag_base = 6'h00;
    else if (stat_wr)
      flag_base = wb_dat_i[`FXU_SW_FLAGS];
  end

  // Flags are sticky; a same-cycle event wins over clear
  always @(posedge clk_i) begin
    if (do_init) begin
      stat <= 16'h0000;
    end else begin
      if (do_clex)
        stat[`FXU_SW_LOW] <= 8'h00;
      else if (stat_wr)
        stat[`FXU_SW_LOW] <= wb_dat_i[`FXU_SW_LOW];
      if (stat_wr) begin
        stat[`FXU_SW_C3] <= wb_dat_i[`FXU_SW_C3];
        stat[`FXU_SW_CC] <= wb_dat_i[`FXU_SW_CC];
      end
      // Remainder clear beats a datapath load
      if (prem_inc) begin
        stat[`FXU_SW_C3] <= 1'b0;
        stat[`FXU_SW_CC] <= 3'h0;
      end else if (cc_we_i) begin
        stat[`FXU_SW_C3] <= cc_i[3];
        stat[`FXU_SW_CC] <= cc_i[2:0];
      end
      if (top_we_i)
        stat[`FXU_SW_TOP] <= top_i;
      stat[`FXU_SW_B] <= busy_i;
      // Only unmasked ones latch and summarise, over a clear-exceptions command; init wins
      if (fault) begin
        stat[`FXU_SW_FLAGS] <= flag_base | unmasked;
        stat[`FXU_SW_ES] <= 1'b1;
        if (sf_hit & unmasked[`FXU_X_IE])
          stat[`FXU_SW_SF] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------
  // Tag word
  // ----------------------------------------------------------
  // Software may only empty entries; others follow contents
  integer i;
  reg [15:0] next_tag;
  always @* begin
    next_tag = tag;
    for (i = 0; i < 8; i = i + 1) begin
      if (tag_wr && wb_dat_i[2*i +: 2] == `FXU_TAG_E)
        next_tag[2*i +: 2] = `FXU_TAG_E;
      else if (tag_valid_i[i] && tag[2*i +: 2] == `FXU_TAG_E &&
               !tag_wr)
        next_tag[2*i +: 2] = 2'h0;
      else if (!tag_valid_i[i])
        next_tag[2*i +: 2] = `FXU_TAG_E;
    end
  end

  // Init empties every entry; live contents refill it next cycle
  always @(posedge clk_i) begin
    if (do_init)
      tag <= `FXU_TAG_EMPTY;
    else
      tag <= next_tag;
  end

  // ----------------------------------------------------------
  // Error pin
  // ----------------------------------------------------------
  // Follows summary; set only while busy, init always clears
  // Release may come while idle; only setting waits for busy
  always @(posedge clk_i) begin
    if (rst_i)
      error_n_o <= 1'b1;
    else if (err_clear)
      error_n_o <= 1'b1;
    else if (busy_i & stat[`FXU_SW_ES])
      error_n_o <= 1'b0;
  end

  // ----------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------
  // One wait state: ack the cycle after strobe, then drop
  // Read data is registered at the taking edge, stands with ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack <= bus_req & ~ack;
      case (wb_adr_i)
        `FXU_A_CTRL: wb_dat_o <= {16'h0000, ctrl};
        `FXU_A_STAT: wb_dat_o <= {16'h0000, stat};
        `FXU_A_TAG: wb_dat_o <= {16'h0000, tag};
        `FXU_A_IPTR: wb_dat_o <= {12'h000, ip_save};
        `FXU_A_DPTR: wb_dat_o <= {12'h000, dp_save};
        `FXU_A_OPC: wb_dat_o <= {21'h000000, opc_save};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule // fxu_exc_unit

// ### fxu_exc_unit_asserts.sv
// Port-level timing checker for the numeric exception unit
module fxu_chk (
  input wire clk_i, // Clock
  input wire rst_i, // Reset, high
  input wire wb_cyc_i, // Bus cycle
  input wire wb_stb_i, // Strobe
  input wire wb_ack_o, // Acknowledge
  input wire op_done_i, // Operation done
  input wire busy_i, // Execution busy
  input wire res_valid_o, // Result kind valid
  input wire stall_o, // Unmasked stop
  input wire [1:0] rnd_mode_o, // Rounding mode
  input wire affine_o, // Affine closure
  input wire error_n_o // Error pin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Bus and datapath timing
  // ----------------------------------------
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_res_follows: assert property (op_done_i |=> res_valid_o)
    else $error("no result after operation");
  a_res_cause: assert property (res_valid_o |-> $past(op_done_i))
    else $error("result without operation");
  a_stall_pair: assert property (stall_o |-> res_valid_o)
    else $error("stall without result");
  // ----------------------------------------
  // Error pin and init state
  // ----------------------------------------
  a_err_set: assert property (stall_o && busy_i |=> !error_n_o)
    else $error("error pin not asserted");
  a_err_busy: assert property ($fell(error_n_o) |-> $past(busy_i))
    else $error("error pin changed while idle");
  a_affine_on: assert property (affine_o)
    else $error("closure not affine");
  a_rnd_init: assert property ($fell(rst_i) |-> rnd_mode_o == 2'h0)
    else $error("rounding not nearest after reset");
  // Main scenarios reached
  cover property (stall_o);
  cover property ($fell(error_n_o));
  cover property (res_valid_o && !stall_o);
endmodule // fxu_chk

bind fxu_exc_unit fxu_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .op_done_i, .busy_i, .res_valid_o, .stall_o, .rnd_mode_o,
  .affine_o, .error_n_o);

// ### fxu_exc_unit_test.sv
// Self-checking bench for the exception and init unit
`include "fxu_defs.vh"
module fxu_exc_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, done = 0;
  logic cc_we = 0, top_we = 0, go = 0;
  logic [3:0] adr = 0, cls = 0, cc = 0;
  logic [2:0] top = 0;
  logic [17:0] ev = 0;
  logic [19:0] ip = 0;
  logic [7:0] tv = 0;
  logic [31:0] wdat = 0, rd;
  wire [31:0] dat_o;
  wire ack, busy, coprocessor_escape_instr, trap, stall, rv, aff, err_n, neg;
  wire [3:0] kind;
  wire [1:0] rnd;
  wire [19:0] hip, hdp;
  wire [10:0] hopc;
  int n_fail = 0, n_checks = 0, n_cyc = 0;

  always #4 clk_i = ~clk_i;

  fxu_exc_unit dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .op_done_i(done), .op_class_i(cls),
    .op_snan_i(ev[0]), .op_qnan_i(ev[1]), .op_badfmt_i(ev[2]),
    .op_indet_i(ev[3]), .op_stack_i(ev[4]), .op_denorm_i(ev[5]),
    .op_divzero_i(ev[6]), .op_zero_i(ev[7]), .op_scl_inf_i(ev[8]),
    .op_scl_neg_i(ev[9]), .op_ovf_i(ev[10]), .op_tiny_i(ev[11]),
    .op_lossy_i(ev[12]), .op_inexact_i(ev[13]), .op_res_neg_i(ev[14]),
    .op_int_dst_i(ev[15]), .op_bcd_dst_i(ev[16]), .op_has_mem_i(ev[17]),
    .cc_i(cc), .cc_we_i(cc_we), .top_i(top), .top_we_i(top_we),
    .tag_valid_i(tv), .esc_start_i(coprocessor_escape_instr), .esc_ip_i(hip), .esc_dp_i(hdp),
    .esc_opc_i(hopc), .busy_i(busy), .res_kind_o(kind), .res_neg_o(neg),
    .res_valid_o(rv), .stall_o(stall), .rnd_mode_o(rnd), .affine_o(aff),
    .error_n_o(err_n));

  fxu_host host_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .idle_i(rv),
    .err_n_i(err_n), .ip_i(ip), .esc_o(coprocessor_escape_instr), .busy_o(busy), .trap_o(trap),
    .ip_o(hip), .dp_o(hdp), .opc_o(hopc));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Classic cycle, held until ack; no fixed latency assumed
  task wb(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc <= 1'b0;
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 16'h0000);
    chk(rd, e);
  endtask
  // One finished operation; result expected the next cycle
  // Minus infinity into the second register is always negative
  task op(input logic [3:0] c, input logic [17:0] v, input logic [3:0] k,
          input logic s);
    logic en;
    en = (k == `FXU_R_NEG_INF_ST1) ? 1'b1 : v[14];
    @(posedge clk_i);
    done <= 1'b1;
    cls <= c;
    ev <= v;
    @(posedge clk_i);
    done <= 1'b0;
    #1;
    chk({rv, stall, neg, kind}, {1'b1, s, en, k});
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, far above the length of the sequence
  always @(posedge clk_i) begin
    n_cyc++;
    if (n_cyc == 4000) begin
      n_fail++;
      close_out;
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`FXU_A_CTRL, 32'h037f);
    rdc(`FXU_A_STAT, 32'h0);
    rdc(`FXU_A_TAG, 32'hffff);
    chk({aff, rnd}, 32'h4);
    rdc(4'h7, 32'h0);
    wb(1'b1, `FXU_A_CMD, `FXU_CMD_INIT);
    // Masked: default results; last op has denormal unmasked, extended load
    op(`FXU_OP_ARITH, 18'h02041, `FXU_R_QNAN, 0);
    op(`FXU_OP_STORE_INT, 18'h08008, `FXU_R_INT_IND, 0);
    op(`FXU_OP_STORE_BCD, 18'h10002, `FXU_R_BCD_IND, 0);
    op(`FXU_OP_ARITH, 18'h00002, `FXU_R_NONE, 0);
    op(`FXU_OP_COMPARE, 18'h00002, `FXU_R_QNAN, 0);
    op(`FXU_OP_LOAD_SD, 18'h00020, `FXU_R_NORMOP, 0);
    op(`FXU_OP_ARITH, 18'h00020, `FXU_R_NORMOP, 0);
    op(`FXU_OP_ARITH, 18'h00040, `FXU_R_INF, 0);
    op(`FXU_OP_ARITH, 18'h00400, `FXU_R_INF, 0);
    op(`FXU_OP_ARITH, 18'h01800, `FXU_R_ZERO, 0);
    op(`FXU_OP_ARITH, 18'h00800, `FXU_R_DENORM, 0);
    op(`FXU_OP_ARITH, 18'h02000, `FXU_R_ROUNDED, 0);
    op(`FXU_OP_SPLIT_EXP, 18'h00080, `FXU_R_NEG_INF_ST1, 0);
    op(`FXU_OP_SCALE, 18'h00180, `FXU_R_QNAN, 0);
    op(`FXU_OP_SCALE, 18'h04300, `FXU_R_ZERO, 0);
    op(`FXU_OP_SCALE, 18'h00100, `FXU_R_INF, 0);
    wb(1'b1, `FXU_A_CTRL, 16'h0f7f);
    op(`FXU_OP_ARITH, 18'h00400, `FXU_R_MAXFIN, 0);
    wb(1'b1, `FXU_A_CTRL, 16'h037d);
    op(`FXU_OP_LOAD_EXT, 18'h00020, `FXU_R_NONE, 0);
    // Unmasked stack fault during a started escape
    wb(1'b1, `FXU_A_CTRL, 16'h0000);
    @(posedge clk_i);
    ip <= 20'h12345;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    op(`FXU_OP_ARITH, 18'h20010, `FXU_R_NONE, 1);
    repeat (2) @(posedge clk_i);
    #1 chk(err_n, 32'h0);
    rdc(`FXU_A_STAT, 32'h00c1);
    rdc(`FXU_A_IPTR, 32'h12345);
    rdc(`FXU_A_DPTR, 32'h12445);
    rdc(`FXU_A_OPC, 32'h345);
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    #1 chk(trap, 32'h1);
    wb(1'b1, `FXU_A_CMD, `FXU_CMD_CLEX);
    @(posedge clk_i);
    #1 chk(err_n, 32'h1);
    rdc(`FXU_A_STAT, 32'h0);
    // A second fault, released by the environment command
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    op(`FXU_OP_ARITH, 18'h00040, `FXU_R_NONE, 1);
    repeat (2) @(posedge clk_i);
    #1 chk(err_n, 32'h0);
    wb(1'b1, `FXU_A_CMD, `FXU_CMD_ENV);
    @(posedge clk_i);
    #1 chk(err_n, 32'h1);
    rdc(`FXU_A_STAT, 32'h0084);
    wb(1'b1, `FXU_A_CMD, `FXU_CMD_CLEX);
    // Condition codes, stack top, tag writes
    @(posedge clk_i);
    cc <= 4'hf;
    cc_we <= 1'b1;
    top <= 3'h5;
    top_we <= 1'b1;
    @(posedge clk_i);
    cc_we <= 1'b0;
    top_we <= 1'b0;
    rdc(`FXU_A_STAT, 32'h6f00);
    wb(1'b1, `FXU_A_CMD, `FXU_CMD_PREM_INC);
    rdc(`FXU_A_STAT, 32'h2800);
    tv <= 8'h01;
    wb(1'b1, `FXU_A_TAG, 16'h0000);
    rdc(`FXU_A_TAG, 32'hfffc);
    tv <= 8'h00;
    wb(1'b1, `FXU_A_CTRL, 16'h1c00);
    wb(1'b1, `FXU_A_CMD, `FXU_CMD_INIT);
    rdc(`FXU_A_CTRL, 32'h037f);
    rdc(`FXU_A_STAT, 32'h0);
    rdc(`FXU_A_TAG, 32'hffff);
    close_out;
  end
endmodule // fxu_exc_unit_test

// ### fxu_host.sv
// Host processor model: issues escapes, traps on a pending error
module fxu_host (
  input wire clk_i, // Clock
  input wire rst_i, // Reset, high
  input wire go_i, // Next escape or wait
  input wire idle_i, // Execution finished
  input wire err_n_i, // Error pin of unit
  input wire [19:0] ip_i, // Instruction address
  output logic esc_o, // Escape started
  output logic busy_o, // Coprocessor busy
  output logic trap_o, // Error interrupt taken
  output wire [19:0] ip_o, // Escape address
  output wire [19:0] dp_o, // Operand address
  output wire [10:0] opc_o // Opcode
);
  timeunit 1ns;
  timeprecision 1ps;
  // Operand and opcode derived from address, easy to predict
  assign ip_o = ip_i;
  assign dp_o = ip_i + 20'h00100;
  assign opc_o = ip_i[10:0];
  // A pending error turns the next escape into a trap, no start
  always @(posedge clk_i) begin
    if (rst_i) begin
      esc_o <= 1'b0;
      busy_o <= 1'b0;
      trap_o <= 1'b0;
    end else begin
      esc_o <= go_i & err_n_i;
      trap_o <= go_i & ~err_n_i;
      if (go_i & err_n_i)
        busy_o <= 1'b1;
      else if (idle_i)
        busy_o <= 1'b0;
    end
  end
endmodule // fxu_host
